// *** include/tks_params.svh ***
// Constants for the touch keyboard event sequencer
`ifndef TKS_PARAMS_SVH
`define TKS_PARAMS_SVH
`define TKS_NOTE_W 5
`define TKS_NOTE_COUNT 5'h1e
`define TKS_NOTE_TOP 5'h1d
`define TKS_TS_W 12
`define TKS_TS_MAX 12'hfff
`define TKS_EVENTS 256
`define TKS_IDX_W 9
`define TKS_POS_W 8
`define TKS_POS_FULL 8'hff
`define TKS_XP_SEVEN 5'h07
`define TKS_XP_FOUR 5'h04
`define TKS_XP_TWO 5'h02
`define TKS_XP_ONE 5'h01
`define TKS_CYC_PER_MS 64'd250000
`define TKS_REC_LEN_MS 64'd25000
`define TKS_MIN_LEN_MS 64'd2000
`define TKS_MAX_LEN_MS 64'd240000
`define TKS_TICKS 64'd4096
`define TKS_LFSR_SEED 8'h5a
`define TKS_LFSR_TAPS 8'hb8
`define TKS_ADDR_CTRL 8'h00
`define TKS_ADDR_DIV 8'h04
`define TKS_ADDR_STATUS 8'h08
`define TKS_ADDR_POS 8'h0c
`define TKS_CTRL_SEQ_BIT 0
`define TKS_STAT_COUNT_LSB 8
`define TKS_POS_END_LSB 16
`endif

// *** include/tks_pkg.sv ***
// Types shared by the touch keyboard event sequencer
`include "tks_params.svh"
package tks_pkg;
  typedef enum logic [2:0] {
    TKS_FREE = 3'h0,
    TKS_ARMED = 3'h1,
    TKS_REC = 3'h3,
    TKS_CUE = 3'h2,
    TKS_PLAY = 3'h6
  } tks_state_t;

  // One stored note edge: pitch code, start flag, tick stamp
  typedef struct packed {
    logic [`TKS_NOTE_W-1:0] note;
    logic is_start;
    logic [`TKS_TS_W-1:0] stamp;
  } tks_event_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } tks_ahb_req_t;
endpackage : tks_pkg

// *** hdl/tks_sequencer.sv ***
// Touch keyboard note-event recorder and looper with an AHB-Lite control slave
// Operation
// - Store at most 256 events, drop later ones
// - Recording stores pitch with cycle time
// - Playback replays pitch at stored offset
// - One key result at a time only
// - Switch picks sequencer or live trigger
// - Chance contact puts random note out
// - Recording passes live pitch and trigger
// - Transpose contacts add 7, 4, 2, 1
// - Own clock times events, scales duration
// - Length caps cycle; play marks end
// - Position rises zero to full scale
// - Counter wraps continuously in free and play modes
// - Record zeroes position, waits first key
// - Play restarts first event, loops forever
// - Store key-down and key-up times
// - Play press holds start, release launches
// - Tempo rescales from 2 s to 4 min
// - Only own keyboard notes are recorded
// - One pitch output, live or recorded
// - Key codes are 5-bit, 30 values
`timescale 1ns/1ps
`default_nettype none
`include "tks_params.svh"
module tks_sequencer #(
  parameter int unsigned EVENTS = `TKS_EVENTS,
  parameter logic [31:0] TICK_CYCLES = 32'((`TKS_REC_LEN_MS * `TKS_CYC_PER_MS) / `TKS_TICKS)
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_KEY_TOUCH,
  input wire logic [4:0] I_KEY_CODE,
  input wire logic [7:0] I_KEY_DYN,
  input wire logic I_CHANCE,
  input wire logic I_RECORD,
  input wire logic I_PLAY,
  input wire logic I_TRANSPOSE_SEVEN_CONTACT,
  input wire logic I_TRANSPOSE_FOUR_CONTACT,
  input wire logic I_TRANSPOSE_TWO_CONTACT,
  input wire logic I_TRANSPOSE_ONE_CONTACT,
  output logic [4:0] O_SEQ_PITCH,
  output logic [4:0] O_KEY_PITCH,
  output logic [7:0] O_KEY_DYN,
  output logic O_ENV_TRIG,
  output logic [7:0] O_POSITION
);
  // Tempo limits scale from the nominal recording length
  localparam logic [31:0] DIV_MIN = 32'((64'(TICK_CYCLES) * `TKS_MIN_LEN_MS) / `TKS_REC_LEN_MS);
  localparam logic [31:0] DIV_MAX = 32'((64'(TICK_CYCLES) * `TKS_MAX_LEN_MS) / `TKS_REC_LEN_MS);

  // Keep a written divider inside the usable tempo range
  function automatic logic [31:0] clamp_div(input logic [31:0] v);
    if (v < DIV_MIN) begin
      return DIV_MIN;
    end
    if (v > DIV_MAX) begin
      return DIV_MAX;
    end
    return v;
  endfunction : clamp_div

  // Add an offset and stop at the top code instead of wrapping
  function automatic logic [4:0] sat_add(input logic [4:0] a, input logic [4:0] b);
    logic [5:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > {1'b0, `TKS_NOTE_TOP}) ? `TKS_NOTE_TOP : s[4:0];
  endfunction : sat_add

  // Fraction pos/end in 256ths of full scale, shift-subtract division
  function automatic logic [7:0] scale_pos(input logic [11:0] pos, input logic [11:0] fin);
    logic [12:0] rem;
    logic [7:0] q;
    rem = {1'b0, pos};
    q = 8'h00;
    if (pos >= fin) begin
      return `TKS_POS_FULL;
    end
    for (int i = 7; i >= 0; i--) begin
      rem = {rem[11:0], 1'b0};
      if (rem >= {1'b0, fin}) begin
        rem = rem - {1'b0, fin};
        q[i] = 1'b1;
      end
    end
    return q;
  endfunction : scale_pos

  tks_pkg::tks_state_t state_q, state_d;
  tks_pkg::tks_event_t mem [EVENTS];
  tks_pkg::tks_event_t cur_ev;
  tks_pkg::tks_ahb_req_t req_q;
  logic trig_seq_q;
  logic [31:0] div_q;
  logic [31:0] div_cnt_q;
  logic tick;
  logic [11:0] pos_q, pos_d;
  logic [11:0] end_q, end_d;
  logic [8:0] count_q;
  logic [8:0] idx_q, idx_d;
  logic [7:0] lfsr_q;
  logic [4:0] live_note_q;
  logic live_gate_prev_q, rec_prev_q, play_prev_q;
  logic [4:0] play_note_q;
  logic play_gate_q;
  logic [4:0] key_clamped, chance_note, live_note, xpose, seq_note;
  logic live_gate, live_rise, live_fall, rec_rise, play_rise, play_fall;
  logic at_end, rec_store, ev_due, seq_gate;
  logic [4:0] live_pick;

  // Live keyboard: keys win over the chance contact, so one note at a time
  assign key_clamped = (I_KEY_CODE > `TKS_NOTE_TOP) ? `TKS_NOTE_TOP : I_KEY_CODE;
  assign chance_note = (lfsr_q[4:0] >= `TKS_NOTE_COUNT) ? lfsr_q[4:0] - `TKS_NOTE_COUNT : lfsr_q[4:0];
  assign live_pick = I_KEY_TOUCH ? key_clamped : chance_note;
  assign live_gate = I_KEY_TOUCH | I_CHANCE;
  assign live_note = live_gate ? live_pick : live_note_q;
  assign live_rise = live_gate & ~live_gate_prev_q;
  assign live_fall = ~live_gate & live_gate_prev_q;
  assign rec_rise = I_RECORD & ~rec_prev_q;
  assign play_rise = I_PLAY & ~play_prev_q;
  assign play_fall = ~I_PLAY & play_prev_q;

  // Transposition offsets summed from the held contacts
  assign xpose = (I_TRANSPOSE_SEVEN_CONTACT ? `TKS_XP_SEVEN : 5'h00)
               + (I_TRANSPOSE_FOUR_CONTACT ? `TKS_XP_FOUR : 5'h00)
               + (I_TRANSPOSE_TWO_CONTACT ? `TKS_XP_TWO : 5'h00)
               + (I_TRANSPOSE_ONE_CONTACT ? `TKS_XP_ONE : 5'h00);

  // One shared pitch line: recorded note in play, live note otherwise
  assign seq_note = sat_add((state_q == tks_pkg::TKS_PLAY) ? play_note_q : live_note, xpose);
  assign seq_gate = (state_q == tks_pkg::TKS_PLAY) ? play_gate_q : live_gate;

  // Tick enable from the tempo divider; the whole loop scales with it
  // A divider of 0 or 1 ticks every cycle; without the guard 0 - 1 would wrap and tick only once every 2^32 cycles
  assign tick = (div_q <= 32'h1) || (div_cnt_q >= div_q - 32'h1);
  assign at_end = (pos_q >= end_q);
  assign rec_store = ((state_q == tks_pkg::TKS_REC && !rec_rise) || (state_q == tks_pkg::TKS_ARMED && live_rise))
                   && (live_rise || live_fall) && (count_q < 9'(EVENTS));
  assign cur_ev = mem[idx_q[7:0]];
  assign ev_due = (state_q == tks_pkg::TKS_PLAY) && (idx_q < count_q) && (cur_ev.stamp <= pos_q);

  // Mode sequencing, position counter and end marker
  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    end_d = end_q;
    idx_d = ev_due ? idx_q + 9'h1 : idx_q;
    case (state_q)
      tks_pkg::TKS_FREE: begin
        if (tick) begin
          pos_d = at_end ? 12'h000 : pos_q + 12'h001;
        end
        if (rec_rise) begin
          state_d = tks_pkg::TKS_ARMED;
          pos_d = 12'h000;
        end else if (play_rise) begin
          state_d = tks_pkg::TKS_CUE;
          pos_d = 12'h000;
        end
      end
      tks_pkg::TKS_ARMED: begin
        pos_d = 12'h000;
        if (play_rise) begin
          state_d = tks_pkg::TKS_CUE;
        end else if (live_rise) begin
          state_d = tks_pkg::TKS_REC;
        end
      end
      tks_pkg::TKS_REC: begin
        if (tick) begin
          pos_d = pos_q + 12'h001;
        end
        if (rec_rise) begin
          state_d = tks_pkg::TKS_ARMED;
          pos_d = 12'h000;
        end else if (play_rise) begin
          end_d = (pos_q == 12'h000) ? 12'h001 : pos_q;
          state_d = tks_pkg::TKS_CUE;
          pos_d = 12'h000;
        end else if (tick && pos_q == `TKS_TS_MAX) begin
          end_d = `TKS_TS_MAX;
          state_d = tks_pkg::TKS_PLAY;
          pos_d = 12'h000;
          idx_d = 9'h000;
        end
      end
      tks_pkg::TKS_CUE: begin
        pos_d = 12'h000;
        idx_d = 9'h000;
        if (rec_rise) begin
          state_d = tks_pkg::TKS_ARMED;
        end else if (play_fall || !I_PLAY) begin
          state_d = tks_pkg::TKS_PLAY;
        end
      end
      tks_pkg::TKS_PLAY: begin
        if (tick && at_end) begin
          pos_d = 12'h000;
          idx_d = 9'h000;
        end else if (tick) begin
          pos_d = pos_q + 12'h001;
        end
        if (rec_rise) begin
          state_d = tks_pkg::TKS_ARMED;
          pos_d = 12'h000;
        end else if (play_rise) begin
          state_d = tks_pkg::TKS_CUE;
          pos_d = 12'h000;
        end
      end
      default: begin
        state_d = tks_pkg::TKS_FREE;
        pos_d = 12'h000;
      end
    endcase
  end

  // State, counters and edge history
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= tks_pkg::TKS_FREE;
      pos_q <= 12'h000;
      end_q <= `TKS_TS_MAX;
      idx_q <= 9'h000;
      div_cnt_q <= 32'h0;
      live_gate_prev_q <= 1'b0;
      rec_prev_q <= 1'b0;
      play_prev_q <= 1'b0;
      lfsr_q <= `TKS_LFSR_SEED;
      live_note_q <= 5'h00;
    end else begin
      state_q <= state_d;
      pos_q <= pos_d;
      end_q <= end_d;
      idx_q <= idx_d;
      div_cnt_q <= tick ? 32'h0 : div_cnt_q + 32'h1;
      live_gate_prev_q <= live_gate;
      rec_prev_q <= I_RECORD;
      play_prev_q <= I_PLAY;
      lfsr_q <= {lfsr_q[6:0], ^(lfsr_q & `TKS_LFSR_TAPS)}; // Free-running so chance notes differ
      live_note_q <= live_note;
    end
  end

  // Event store: only the keyboard path can write it; no reset on the array
  always_ff @(posedge I_MCLK) begin
    if (rec_store) begin
      mem[count_q[7:0]] <= '{note: live_note, is_start: live_rise, stamp: pos_q};
    end
  end

  // Event count: cleared on arming, stops at capacity
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      count_q <= 9'h000;
    end else if (state_d == tks_pkg::TKS_ARMED && state_q != tks_pkg::TKS_ARMED) begin
      count_q <= 9'h000;
    end else if (rec_store) begin
      count_q <= count_q + 9'h1;
    end
  end

  // Replayed note and gate; the gate drops at every wrap
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      play_note_q <= 5'h00;
      play_gate_q <= 1'b0;
    end else if (state_q != tks_pkg::TKS_PLAY || (tick && at_end)) begin
      play_gate_q <= 1'b0;
    end else if (ev_due) begin
      play_note_q <= cur_ev.note;
      play_gate_q <= cur_ev.is_start;
    end
  end

  // Registered outputs toward the voice
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_SEQ_PITCH <= 5'h00;
      O_KEY_PITCH <= 5'h00;
      O_KEY_DYN <= 8'h00;
      O_ENV_TRIG <= 1'b0;
      O_POSITION <= 8'h00;
    end else begin
      O_SEQ_PITCH <= seq_note;
      O_KEY_PITCH <= live_note;
      O_KEY_DYN <= I_KEY_DYN;
      O_ENV_TRIG <= trig_seq_q ? seq_gate : live_gate;
      O_POSITION <= scale_pos(pos_q, end_q);
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  logic addr_ok;
  logic [7:0] rd_addr;
  logic wr_ctrl, wr_div;
  logic [31:0] rd_mux;
  assign addr_ok = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign rd_addr = I_HADDR[7:0];
  assign wr_ctrl = req_q.valid & req_q.write & (req_q.addr == `TKS_ADDR_CTRL);
  assign wr_div = req_q.valid & req_q.write & (req_q.addr == `TKS_ADDR_DIV);
  // A read right after a write to the same word sees the new data
  assign rd_mux = (rd_addr == `TKS_ADDR_CTRL) ? (wr_ctrl ? {31'h0, I_HWDATA[`TKS_CTRL_SEQ_BIT]}
                                                         : {31'h0, trig_seq_q})
                : (rd_addr == `TKS_ADDR_DIV) ? (wr_div ? clamp_div(I_HWDATA) : div_q)
                : (rd_addr == `TKS_ADDR_STATUS) ? ({20'h0, count_q, 3'h0} << (`TKS_STAT_COUNT_LSB - 3))
                  | {29'h0, state_q}
                : (rd_addr == `TKS_ADDR_POS) ? ({4'h0, end_q, 16'h0} | {20'h0, pos_q})
                : 32'h0;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      req_q <= '0;
      O_HRDATA <= 32'h0;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      if (I_HREADY) begin
        req_q <= '{addr: I_HADDR[7:0], write: I_HWRITE, valid: addr_ok};
      end
      if (addr_ok && !I_HWRITE) begin
        O_HRDATA <= rd_mux;
      end
    end
  end

  // Software registers: trigger source and tempo divider
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      trig_seq_q <= 1'b0;
      div_q <= TICK_CYCLES;
    end else begin
      if (wr_ctrl) begin
        trig_seq_q <= I_HWDATA[`TKS_CTRL_SEQ_BIT];
      end
      if (wr_div) begin
        div_q <= clamp_div(I_HWDATA);
      end
    end
  end

  // Checks
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  a_count_cap: assert property (count_q <= 9'(EVENTS))
    else $error("event count above capacity");
  a_rec_store_cnt: assert property (rec_store |=> count_q == $past(count_q) + 9'h1)
    else $error("recorded edge not counted");
  a_armed_hold: assert property (state_q == tks_pkg::TKS_ARMED |-> pos_q == 12'h000)
    else $error("position moved before first key");
  a_cue_hold: assert property (state_q == tks_pkg::TKS_CUE |=> pos_q == 12'h000 && idx_q == 9'h000)
    else $error("cue did not hold at start");
  a_end_mark: assert property (state_q == tks_pkg::TKS_REC && play_rise && !rec_rise && pos_q != 12'h000
    |=> end_q == $past(pos_q) && state_q == tks_pkg::TKS_CUE)
    else $error("play contact did not mark sequence end");
  a_play_wrap: assert property (state_q == tks_pkg::TKS_PLAY && tick && at_end && !rec_rise && !play_rise
    |=> pos_q == 12'h000 && idx_q == 9'h000 ##1 O_POSITION == 8'h00)
    else $error("playback did not wrap to start");
  a_pitch_top: assert property (O_SEQ_PITCH <= `TKS_NOTE_TOP && O_KEY_PITCH <= `TKS_NOTE_TOP)
    else $error("pitch code out of range");
  a_pass_live: assert property (state_q == tks_pkg::TKS_REC && xpose == 5'h00 |=> O_SEQ_PITCH == $past(live_note))
    else $error("recording did not pass live pitch");
  a_trig_route: assert property (##1 O_ENV_TRIG == ($past(trig_seq_q) ? $past(seq_gate) : $past(live_gate)))
    else $error("trigger source routing wrong");
  a_tick_gap: assert property (tick && div_q > 32'h1 |=> !tick)
    else $error("tick enable too close");

  c_rec_then_play: cover property (state_q == tks_pkg::TKS_REC ##[1:1000] state_q == tks_pkg::TKS_PLAY);
  c_replay_event: cover property (ev_due && cur_ev.is_start);
  c_store_full: cover property (count_q == 9'(EVENTS));
  c_loop_wrap: cover property (state_q == tks_pkg::TKS_PLAY && tick && at_end);
endmodule : tks_sequencer
`default_nettype wire

// *** verif/tks_performer.sv ***
// Performer model: key and contact touches for the sequencer
`timescale 1ns/1ps
`default_nettype none
module tks_performer (
  input wire logic i_clk,
  output logic o_touch,
  output logic [4:0] o_code,
  output logic [7:0] o_dyn,
  output logic o_chance,
  output logic o_record,
  output logic o_play,
  output logic [3:0] o_xp
);
  // Nothing touched at start
  initial begin
    o_touch = 1'b0;
    o_code = 5'h00;
    o_dyn = 8'h00;
    o_chance = 1'b0;
    o_record = 1'b0;
    o_play = 1'b0;
    o_xp = 4'h0;
  end
  // One finger only: a new touch replaces the code
  task key_set(input logic down, input logic [4:0] code);
    o_code <= code;
    o_dyn <= down ? {3'h4, code} : 8'h00;
    o_touch <= down;
  endtask : key_set
  task key_down(input logic [4:0] code);
    key_set(1'b1, code);
  endtask : key_down
  // Dynamic level falls away on release; the code stays
  task key_up();
    key_set(1'b0, o_code);
  endtask : key_up
  // Held two cycles so the rising edge cannot be missed; two toggles leave it released
  task tap_record();
    o_record <= ~o_record;
    repeat (2) @(posedge i_clk);
    o_record <= ~o_record;
  endtask : tap_record
  task tap_chance();
    o_chance <= ~o_chance;
    repeat (2) @(posedge i_clk);
    o_chance <= ~o_chance;
  endtask : tap_chance
  // Touching play is what closes a recording
  task set_play(input logic v);
    o_play <= v;
  endtask : set_play
  // Bit 3 is the seven-step contact, bit 0 the one-step contact
  task set_xp(input logic [3:0] v);
    o_xp <= v;
  endtask : set_xp
endmodule : tks_performer
`default_nettype wire

// *** verif/touch_keyboard_event_sequencer_tb.sv ***
// Self-checking testbench for the touch keyboard event sequencer
`timescale 1ns/1ps
`default_nettype none
module touch_keyboard_event_sequencer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic touch, chance, rec, play;
  logic [4:0] code, key_pitch, seq_pitch;
  logic [7:0] dyn, key_dyn, pos;
  logic [3:0] xp;
  logic trig;
  logic [31:0] rd;
  int n_fail = 0;
  int checks_done = 0;
  int n;

  // Short tick keeps loops to a few hundred cycles
  tks_sequencer #(.TICK_CYCLES(32'h8)) DUT (
    .I_MCLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_KEY_TOUCH(touch), .I_KEY_CODE(code), .I_KEY_DYN(dyn), .I_CHANCE(chance),
    .I_RECORD(rec), .I_PLAY(play), .I_TRANSPOSE_SEVEN_CONTACT(xp[3]),
    .I_TRANSPOSE_FOUR_CONTACT(xp[2]), .I_TRANSPOSE_TWO_CONTACT(xp[1]),
    .I_TRANSPOSE_ONE_CONTACT(xp[0]), .O_SEQ_PITCH(seq_pitch), .O_KEY_PITCH(key_pitch),
    .O_KEY_DYN(key_dyn), .O_ENV_TRIG(trig), .O_POSITION(pos)
  );

  tks_performer pf (
    .i_clk(clk), .o_touch(touch), .o_code(code), .o_dyn(dyn), .o_chance(chance),
    .o_record(rec), .o_play(play), .o_xp(xp)
  );

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  task wt(input int c);
    repeat (c) @(posedge clk);
  endtask : wt

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  // Address phase on: select, NONSEQ, word size; off: deselected and IDLE
  task bus_req(input logic on);
    hsel <= on;
    htrans <= {on, 1'b0};
    hsize <= {1'b0, on, 1'b0};
  endtask : bus_req

  // One AHB-Lite single transfer; waits on hready, never on a fixed count
  task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    bus_req(1'b1);
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    bus_req(1'b0);
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : ahb

  // Wait for a replayed pitch; count the cycles it took
  task wait_pitch(input logic [4:0] p, input int lim);
    n = 0;
    while (seq_pitch !== p && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("pitch reached", 32'(p), 32'(seq_pitch));
  endtask : wait_pitch

  task t_regs();
    ahb(8'h00, 1'b0, 32'h0); chk("ctrl reset", 32'h0, rd);
    ahb(8'h04, 1'b0, 32'h0); chk("div reset", 32'h8, rd);
    ahb(8'h08, 1'b0, 32'h0); chk("status reset", 32'h0, rd);
    ahb(8'h10, 1'b0, 32'h0); chk("unmapped", 32'h0, rd);
    ahb(8'h04, 1'b1, 32'h64);
    ahb(8'h04, 1'b0, 32'h0); chk("div clamp high", 32'h4c, rd);
    ahb(8'h04, 1'b1, 32'h8);
    ahb(8'h08, 1'b1, 32'hff);
    ahb(8'h08, 1'b0, 32'h0); chk("status read only", 32'h0, rd);
    $display("regs test done");
  endtask : t_regs

  task t_live();
    pf.key_down(5'h0a);
    wt(3);
    chk("key pitch", 32'h0a, 32'(key_pitch));
    chk("seq pitch live", 32'h0a, 32'(seq_pitch));
    chk("live trig", 32'h1, 32'(trig));
    chk("key dyn", 32'h8a, 32'(key_dyn));
    pf.set_xp(4'h8);
    wt(3);
    chk("transpose seven", 32'h11, 32'(seq_pitch));
    pf.set_xp(4'hf);
    wt(3);
    chk("transpose all", 32'h18, 32'(seq_pitch));
    pf.key_down(5'h14);
    pf.set_xp(4'hc);
    wt(3);
    chk("transpose saturate", 32'h1d, 32'(seq_pitch));
    pf.set_xp(4'h0);
    pf.key_down(5'h1f);
    wt(3);
    chk("code clamp", 32'h1d, 32'(seq_pitch));
    pf.key_up();
    wt(3);
    chk("trig off", 32'h0, 32'(trig));
    pf.tap_chance();
    wt(3);
    chk("chance in range", 32'h1, 32'(key_pitch <= 5'h1d));
    $display("live test done");
  endtask : t_live

  task t_seq();
    ahb(8'h00, 1'b1, 32'h1);
    pf.tap_record();
    wt(40);
    ahb(8'h08, 1'b0, 32'h0); chk("armed", 32'h1, rd & 32'h7);
    chk("armed pos", 32'h0, 32'(pos));
    pf.key_down(5'h05);
    wt(40);
    chk("rec pass", 32'h05, 32'(seq_pitch));
    chk("rec trig", 32'h1, 32'(trig));
    pf.key_up();
    wt(40);
    pf.key_down(5'h0c);
    wt(40);
    pf.key_up();
    wt(16);
    pf.set_play(1'b1);
    wt(40);
    ahb(8'h08, 1'b0, 32'h0); chk("cue", 32'h2, rd & 32'h7);
    chk("event count", 32'h4, (rd >> 8) & 32'h1ff);
    chk("cue pos", 32'h0, 32'(pos));
    ahb(8'h0c, 1'b0, 32'h0);
    n = int'((rd >> 16) & 32'hfff);
    chk("end in range", 32'h1, 32'(n >= 15 && n <= 19));
    pf.set_play(1'b0);
    wait_pitch(5'h05, 20);
    chk("seq trig", 32'h1, 32'(trig));
    wait_pitch(5'h0c, 200);
    chk("replay time", 32'h1, 32'(n >= 40 && n <= 100));
    chk("pos mid", 32'h1, 32'(pos >= 8'h70 && pos <= 8'hc0));
    wait_pitch(5'h05, 300);
    chk("looped", 32'h1, 32'(n > 0));
    $display("sequence test done");
  endtask : t_seq

  // Fill the store past capacity: 260 note edges, only 256 may be kept
  task t_full();
    pf.tap_record();
    wt(4);
    for (int i = 0; i < 130; i++) begin
      pf.key_down(5'(i % 30));
      wt(2);
      pf.key_up();
      wt(2);
    end
    ahb(8'h08, 1'b0, 32'h0); chk("store full", 32'h100, (rd >> 8) & 32'h1ff);
    chk("still recording", 32'h3, rd & 32'h7);
    $display("capacity test done");
  endtask : t_full

  task test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Hang guard, well beyond the roughly one thousand cycles the tests need
  initial begin
    wt(20000);
    n_fail++;
    $display("Error watchdog expected done seen hang");
    test_done();
  end

  initial begin
    wt(10);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_live();
    t_seq();
    t_full();
    test_done();
  end
endmodule : touch_keyboard_event_sequencer_tb
`default_nettype wire
